//--- rtl/dcdc_ctrl_pkg.sv
// Constants, register map and carrier types for the converter control block.
// Assumes a single 125 MHz clock and an APB register bus.
// Function
// RQ1 - Enable writes held until ACTIVE state
// RQ2 - Sequencer sets enable bit when starting converter
// RQ3 - Start slot: 0 never, 1-14 slot, 15 active
// RQ4 - Shutdown slot 1-14; 0 and 15 at OFF
// RQ5 - Enable bits aliased at two addresses
// RQ6 - Enable bits 0-5 are requests; status separate
// RQ7 - Bucks clocked 2.048MHz, boosts 1.024MHz
// RQ8 - LDO select overrides performance bit
// RQ9 - Performance bit: 1 active, 0 standby
// RQ10 - Test bit 4 forces fixed-frequency PWM
// RQ11 - Trigger select: register bit or request inputs
// RQ12 - Global hibernate pin forces all low-power
// RQ13 - Low-power behaviour field decode
// RQ14 - Voltage code 25mV steps from 0.85V
// RQ15 - Image code replaces voltage while triggered
// RQ16 - Voltage changes applied while running
// RQ17 - Bit 10 clear discharges disabled output
// RQ18 - Modes only apply to enabled converter
// RQ19 - Software configures request pins first
// RQ20 - Software spreads converters over slots
// RQ21 - Preset modes load fixed start slots
// RQ22 - Slot advances every 1.28ms
// RQ23 - Slot counter issues enables in order
package dcdc_ctrl_pkg;
  localparam int NCONV = 6;
  localparam logic [7:0] ADDR_ENA_A = 8'h0d;
  localparam logic [7:0] ADDR_ENA_B = 8'hb0;
  localparam logic [7:0] ADDR_PERF = 8'hb1;
  localparam logic [7:0] ADDR_LDO = 8'hb2;
  localparam logic [7:0] ADDR_HIB = 8'hb3;
  localparam logic [7:0] ADDR_STATUS = 8'hb9;
  localparam logic [7:0] ADDR_SEQ = 8'hc6;
  localparam logic [7:0] ADDR_SLOTS [NCONV] = '{8'hb5, 8'hb8, 8'hbb, 8'hbe, 8'hc1, 8'hc4};
  localparam logic [7:0] ADDR_VOLT [NCONV] = '{8'hb4, 8'h00, 8'hba, 8'hbd, 8'h00, 8'hc3};
  localparam logic [7:0] ADDR_LP [NCONV] = '{8'hb6, 8'h00, 8'hbc, 8'hbf, 8'h00, 8'hc5};
  localparam logic [7:0] ADDR_TEST [NCONV] = '{8'hf8, 8'h00, 8'hfa, 8'hfb, 8'h00, 8'hfd};
  localparam logic [5:0] BUCK_MASK = 6'h2d;
  localparam logic [5:0] PERF_RESET = 6'h2d;
  localparam logic [5:0] LDO_RESET = 6'h00;
  localparam int START_LSB = 10;
  localparam int SHUT_LSB = 6;
  localparam int FLOAT_BIT = 10;
  localparam int PWM_BIT = 4;
  localparam int TRIG_LSB = 8;
  localparam int BEH_LSB = 12;
  localparam logic [3:0] SLOT_NEVER = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'he;
  localparam logic [3:0] SLOT_ACTIVE = 4'hf;
  localparam logic [2:0] BEH_RESET = 3'h1;
  localparam logic [6:0] IMG_RESET = 7'h06;
  localparam logic [6:0] VOLT_RESET = 7'h0e;
  localparam logic [15:0] LP_RESET = 16'h1006;
  localparam logic [3:0] PRESET_SLOT [NCONV] = '{4'h2, 4'h0, 4'h6, 4'h4, 4'h0, 4'h3};
  localparam real SLOT_MS = 1.28;
  localparam real CLK_MHZ = 125.0;
  localparam int SLOT_CYCLES = int'(SLOT_MS * CLK_MHZ * 1000.0);
  localparam real BUCK_MHZ = 2.048;
  localparam real BOOST_MHZ = 1.024;
  localparam int BUCK_HALF = int'(CLK_MHZ / BUCK_MHZ / 2.0);
  localparam int BOOST_HALF = int'(CLK_MHZ / BOOST_MHZ / 2.0);
  typedef enum logic [1:0] {MODE_OFF, MODE_ACTIVE, MODE_STANDBY, MODE_LDO} conv_mode_e;
  typedef struct packed {
    logic [2:0] trig;
    logic       ena;
  } lp_in_s;
  typedef struct packed {
    conv_mode_e mode;
    logic [6:0] code;
    logic       on;
    logic       discharge;
    logic       fixedPwm;
  } conv_out_s;
endpackage : dcdc_ctrl_pkg

//--- rtl/dcdc_converter_control.sv
// Six-converter control: enables, timeslot sequencer, modes, voltages.
// Assumes APB master on clk, request pins asynchronous, power state from system logic.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dcdc_converter_control
  import dcdc_ctrl_pkg::*;
#(
  parameter int SLOT_COUNT = SLOT_CYCLES,
  parameter bit DEV_MODE   = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [9:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              startupReq,
  input  wire logic              shutdownReq,
  input  wire logic              convInhibit,
  input  wire lp_in_s            lowpowerReqIn,
  output conv_out_s [NCONV-1:0]  convOut,
  output logic      [NCONV-1:0]  convClk,
  output logic                   activeState,
  output logic                   offState
);
  typedef enum logic [2:0] {ST_OFF, ST_START, ST_ACTIVE, ST_STOP} seq_e;
  seq_e seqState;
  logic [5:0]  converterOnRequest, perf, ldoSel, liveOn;
  logic [15:0] slots [NCONV];
  logic [15:0] volt [NCONV];
  logic [15:0] lp [NCONV];
  logic [15:0] test [NCONV];
  logic        hibBit;
  logic [3:0]  slotNum;
  logic [31:0] slotTimer;
  logic [3:0]  sync1, sync2;
  logic [7:0]  bucCnt;
  logic [7:0]  booCnt;
  logic [1:0]  startSync1, startSync2;

  wire [7:0] regAddr  = paddr[9:2];
  wire       acc      = psel && penable;
  wire       wrEn     = acc && pwrite && clkEn;
  wire       hitEna   = regAddr == ADDR_ENA_A || regAddr == ADDR_ENA_B; // see RQ5
  wire       slotTick = slotTimer == SLOT_COUNT - 1;
  wire       globalHib = sync2[3];
  wire       startIn   = startSync2[0];
  wire       stopIn    = startSync2[1];
  wire [3:0] trigVec   = {sync2[2:0], hibBit};
  wire       slotEdge  = slotTick && (seqState == ST_START || seqState == ST_STOP);

  // Pin inputs through two flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      startSync1 <= 2'h0;
      startSync2 <= 2'h0;
    end else if (clkEn) begin
      sync1 <= {lowpowerReqIn.ena, lowpowerReqIn.trig};
      sync2 <= sync1;
      startSync1 <= {shutdownReq, startupReq};
      startSync2 <= startSync1;
    end
  end

  // Slot interval counter
  always_ff @(posedge clk) begin
    if (sys_rst || seqState == ST_OFF || seqState == ST_ACTIVE) begin
      slotTimer <= 32'h0000_0000;
    end else if (clkEn) begin
      slotTimer <= slotTick ? 32'h0000_0000 : slotTimer + 32'h0000_0001; // see RQ22
    end
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seqState <= ST_OFF;
      slotNum  <= SLOT_NEVER;
    end else if (clkEn) begin
      unique case (seqState)
        ST_OFF: if (startIn) begin
          seqState <= ST_START;
          slotNum  <= 4'h1;
        end
        ST_START: if (slotTick) begin
          if (slotNum == SLOT_LAST) begin
            seqState <= ST_ACTIVE;
            slotNum  <= SLOT_ACTIVE;
          end else begin
            slotNum <= slotNum + 4'h1; // see RQ23
          end
        end
        ST_ACTIVE: if (stopIn) begin
          seqState <= ST_STOP;
          slotNum  <= 4'h1;
        end
        ST_STOP: if (slotTick) begin
          if (slotNum == SLOT_LAST) begin
            seqState <= ST_OFF;
            slotNum  <= SLOT_NEVER;
          end else begin
            slotNum <= slotNum + 4'h1;
          end
        end
      endcase
    end
  end

  // Per-converter enable request and live enable
  for (genvar i = 0; i < NCONV; i++) begin : g_conv
    wire [3:0] st = slots[i][START_LSB +: 4];
    wire [3:0] sd = slots[i][SHUT_LSB +: 4];
    wire seqOn  = (seqState == ST_START && slotEdge && st == slotNum && st != SLOT_NEVER)
               || (seqState == ST_START && slotTick && slotNum == SLOT_LAST
                   && st == SLOT_ACTIVE); // see RQ3
    wire sdHit  = seqState == ST_STOP && slotEdge && sd == slotNum
               && sd != SLOT_NEVER && sd != SLOT_ACTIVE; // see RQ4
    wire offAll = seqState == ST_STOP && slotTick && slotNum == SLOT_LAST; // see RQ4
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        converterOnRequest[i] <= 1'b0;
        liveOn[i] <= 1'b0;
      end else if (clkEn) begin
        if (seqOn) begin
          converterOnRequest[i] <= 1'b1; // see RQ2
        end else if (sdHit || offAll) begin
          converterOnRequest[i] <= 1'b0;
        end else if (wrEn && hitEna) begin
          converterOnRequest[i] <= pwdata[i]; // see RQ5
        end
        // Held until ACTIVE, apart from sequencer actions
        if (seqOn) begin
          liveOn[i] <= 1'b1;
        end else if (sdHit || offAll || seqState == ST_OFF) begin
          liveOn[i] <= 1'b0;
        end else if (seqState == ST_ACTIVE) begin
          liveOn[i] <= converterOnRequest[i]; // see RQ1
        end
      end
    end
  end

  // Register storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      perf   <= PERF_RESET;
      ldoSel <= LDO_RESET;
      hibBit <= 1'b0;
      for (int i = 0; i < NCONV; i++) begin
        slots[i] <= {2'b00, PRESET_SLOT[i], 10'h000}; // see RQ21
        volt[i]  <= {9'h000, VOLT_RESET};
        lp[i]    <= LP_RESET; // see RQ13
        test[i]  <= 16'h0000;
      end
    end else if (wrEn) begin
      if (regAddr == ADDR_PERF) perf <= pwdata[5:0] & BUCK_MASK;
      if (regAddr == ADDR_LDO) ldoSel <= pwdata[5:0] & BUCK_MASK;
      if (regAddr == ADDR_HIB) hibBit <= pwdata[0];
      for (int i = 0; i < NCONV; i++) begin
        if (regAddr == ADDR_SLOTS[i]) begin
          slots[i][SHUT_LSB +: 4] <= pwdata[SHUT_LSB +: 4];
          if (DEV_MODE) slots[i][START_LSB +: 4] <= pwdata[START_LSB +: 4]; // see RQ21
        end
        if (BUCK_MASK[i] && regAddr == ADDR_VOLT[i]) volt[i] <= pwdata[15:0]; // see RQ16
        if (BUCK_MASK[i] && regAddr == ADDR_LP[i]) lp[i] <= pwdata[15:0];
        if (BUCK_MASK[i] && regAddr == ADDR_TEST[i]) test[i] <= pwdata[15:0];
      end
    end
  end

  // Read mux
  logic [15:0] rdSel;
  logic        hit;
  always_comb begin
    rdSel = 16'h0000;
    hit   = 1'b1;
    if (hitEna) rdSel = {10'h000, converterOnRequest}; // see RQ6
    else if (regAddr == ADDR_PERF) rdSel = {10'h000, perf};
    else if (regAddr == ADDR_LDO) rdSel = {10'h000, ldoSel};
    else if (regAddr == ADDR_HIB) rdSel = {15'h0000, hibBit};
    else if (regAddr == ADDR_STATUS) rdSel = {10'h000, liveOn & ~{NCONV{convInhibit}}};
    else if (regAddr == ADDR_SEQ) rdSel = {9'h000, seqState, slotNum};
    else begin
      hit = 1'b0;
      for (int i = 0; i < NCONV; i++) begin
        if (regAddr == ADDR_SLOTS[i]) begin
          rdSel = slots[i];
          hit   = 1'b1;
        end
        if (BUCK_MASK[i] && regAddr == ADDR_VOLT[i]) begin
          rdSel = volt[i];
          hit   = 1'b1;
        end
        if (BUCK_MASK[i] && regAddr == ADDR_LP[i]) begin
          rdSel = lp[i];
          hit   = 1'b1;
        end
        if (BUCK_MASK[i] && regAddr == ADDR_TEST[i]) begin
          rdSel = test[i];
          hit   = 1'b1;
        end
      end
    end
  end

  // APB answer: no wait states, pready high in the first access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? {16'h0000, rdSel} : 32'h0000_0000;
    end
  end

  // Converter outputs
  for (genvar i = 0; i < NCONV; i++) begin : g_out
    wire [1:0] trigSel = lp[i][TRIG_LSB +: 2];
    wire [2:0] beh     = lp[i][BEH_LSB +: 3];
    wire       lpOn    = trigVec[trigSel] || globalHib; // see RQ11 see RQ12
    wire       img     = lpOn && beh[0] && beh != 3'h7;  // see RQ15
    wire       forceStb = lpOn && beh[2:1] == 2'b01;
    wire       forceLdo = lpOn && beh[2:1] == 2'b10;
    wire       lpOff   = lpOn && beh[2:1] == 2'b11;      // see RQ13
    wire       on      = liveOn[i] && !convInhibit && !lpOff; // see RQ6
    wire       buck    = BUCK_MASK[i];
    conv_mode_e m;
    always_comb begin
      if (!on) m = MODE_OFF; // see RQ18
      else if (!buck) m = MODE_ACTIVE;
      else if (ldoSel[i] || forceLdo) m = MODE_LDO; // see RQ8
      else if (forceStb || !perf[i]) m = MODE_STANDBY; // see RQ9
      else m = MODE_ACTIVE;
    end
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        convOut[i] <= '0;
      end else if (clkEn) begin
        convOut[i].mode      <= m;
        convOut[i].on        <= on;
        convOut[i].code      <= img ? lp[i][6:0] : volt[i][6:0]; // see RQ14 see RQ15
        convOut[i].discharge <= !on && buck && !volt[i][FLOAT_BIT]; // see RQ17
        convOut[i].fixedPwm  <= on && buck && test[i][PWM_BIT]; // see RQ10
      end
    end
  end

  // Switching clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bucCnt <= 8'h00;
      booCnt <= 8'h00;
      convClk <= 6'h00;
    end else if (clkEn) begin
      bucCnt <= (bucCnt == 8'(BUCK_HALF - 1)) ? 8'h00 : bucCnt + 8'h01;
      booCnt <= (booCnt == 8'(BOOST_HALF - 1)) ? 8'h00 : booCnt + 8'h01;
      for (int i = 0; i < NCONV; i++) begin
        if (BUCK_MASK[i] && bucCnt == 8'(BUCK_HALF - 1)) convClk[i] <= !convClk[i]; // see RQ7
        if (!BUCK_MASK[i] && booCnt == 8'(BOOST_HALF - 1)) convClk[i] <= !convClk[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activeState <= 1'b0;
      offState <= 1'b1;
    end else if (clkEn) begin
      activeState <= seqState == ST_ACTIVE;
      offState <= seqState == ST_OFF;
    end
  end

  ena_held_a: assert property (@(posedge clk) disable iff (sys_rst)
    seqState == ST_OFF |=> liveOn == 6'h00) else $error("enable active while off"); // see RQ1
  apb_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
    psel && !penable && clkEn |=> pready) else $error("no ready");
  ldo_over_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && liveOn[0] && !convInhibit && ldoSel[0] && lp[0][BEH_LSB+1 +: 2] != 2'b11
    |=> convOut[0].mode == MODE_LDO) else $error("ldo override"); // see RQ8
  off_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && !liveOn[2] |=> convOut[2].mode == MODE_OFF) else $error("mode when off"); // see RQ18
  seq_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && g_conv[0].seqOn |=> converterOnRequest[0]) else $error("seq no set"); // see RQ2
  dis_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && !liveOn[3] && !volt[3][FLOAT_BIT] |=> convOut[3].discharge)
    else $error("no discharge"); // see RQ17
  pwm_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && g_out[5].on && test[5][PWM_BIT] |=> convOut[5].fixedPwm)
    else $error("no pwm"); // see RQ10
  slot_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    slotTimer < SLOT_COUNT) else $error("slot overrun"); // see RQ22
  c_start: cover property (@(posedge clk) seqState == ST_START ##1 seqState == ST_ACTIVE);
  c_stop: cover property (@(posedge clk) seqState == ST_STOP ##1 seqState == ST_OFF);
  c_img: cover property (@(posedge clk) g_out[0].img && liveOn[0]);
endmodule : dcdc_converter_control
`default_nettype wire

//--- sim/apb_host_model.sv
// APB host model: drives register transfers into the converter control block.
// Assumes the slave answers with pready; the bench watchdog ends any hang.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [9:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
  end
  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

//--- sim/dcdc_converter_control_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes a short slot count and the preset start slots.
`timescale 1ns/1ps
`default_nettype none
module dcdc_converter_control_tb_top;
  import dcdc_ctrl_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [15:0] d;} row_s;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  psel, penable, pwrite, pready, pslverr;
  logic [9:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  err;
  logic                  startupReq = 1'b0;
  logic                  shutdownReq = 1'b0;
  logic                  convInhibit = 1'b0;
  logic                  clkEn = 1'b1;
  lp_in_s                lpIn = '0;
  conv_out_s [NCONV-1:0] convOut;
  logic [NCONV-1:0]      convClk;
  logic [NCONV-1:0]      held;
  logic                  activeState, offState;
  int                    num_errors = 0;
  int                    checks_done = 0;
  int                    n0, n1;
  row_s                  rows [8];
  always #4 clk = ~clk;
  apb_host_model u_apb_host_model (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dcdc_converter_control #(.SLOT_COUNT(20), .DEV_MODE(1'b0)) u_dcdc_converter_control (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startupReq(startupReq), .shutdownReq(shutdownReq),
    .convInhibit(convInhibit), .lowpowerReqIn(lpIn), .convOut(convOut),
    .convClk(convClk), .activeState(activeState), .offState(offState));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    u_apb_host_model.xfer(1'b1, {a, 2'b00}, {16'h0000, d}, rd, err);
    repeat (2) @(posedge clk); // Let registered outputs follow
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    u_apb_host_model.xfer(1'b0, {a, 2'b00}, 32'h0000_0000, rd, err);
  endtask : reg_rd
  task automatic wait_flag(input int which);
    int n;
    n = 0;
    while (n < 2000 && (which ? activeState : offState) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    if ((which ? activeState : offState) !== 1'b1) num_errors++;
    repeat (4) @(posedge clk);
  endtask : wait_flag
  task automatic stop_test();
    $display("Checks done %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    rows = '{'{ADDR_PERF, 1'b0, 16'h002d}, '{ADDR_LDO, 1'b0, 16'h0000},
             '{ADDR_LP[0], 1'b0, 16'h1006}, '{ADDR_TEST[0], 1'b0, 16'h0000},
             '{ADDR_LP[2], 1'b0, 16'h1006}, '{ADDR_ENA_A, 1'b1, 16'h0002},
             '{ADDR_ENA_B, 1'b0, 16'h0002}, '{ADDR_ENA_A, 1'b0, 16'h0002}};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("offState", offState, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].w) reg_wr(rows[i].a, rows[i].d);
      else reg_rd(rows[i].a);
      if (!rows[i].w) chk("row read", rd, {16'h0000, rows[i].d});
    end
    u_apb_host_model.xfer(1'b0, 10'h3fc, 32'h0000_0000, rd, err);
    chk("unmapped err", err, 1'b1);
    chk("held enable", convOut[1].on, 1'b0);
    startupReq <= 1'b1;
    repeat (73) @(posedge clk);
    chk("slot2 on", convOut[0].on, 1'b1);
    chk("slot6 off", convOut[2].on, 1'b0);
    wait_flag(1);
    chk("applied enable", convOut[1].on, 1'b1);
    reg_rd(ADDR_ENA_B);
    chk("sequencer enables", rd, 32'h0000_002f);
    chk("active mode", convOut[0].mode, MODE_ACTIVE);
    n0 = 0;
    n1 = 0;
    held = convClk;
    repeat (620) begin
      @(posedge clk);
      n0 += (convClk[0] && !held[0]) ? 1 : 0;
      n1 += (convClk[1] && !held[1]) ? 1 : 0;
      held = convClk;
    end
    chk("buck clock", (n0 >= 9 && n0 <= 11), 1'b1);
    chk("boost clock", (n1 >= 4 && n1 <= 6), 1'b1);
    clkEn <= 1'b0;
    @(posedge clk);
    held = convClk;
    repeat (100) @(posedge clk);
    chk("frozen clocks", convClk, held);
    clkEn <= 1'b1;
    reg_wr(ADDR_PERF, 16'h002c);
    chk("standby", convOut[0].mode, MODE_STANDBY);
    reg_wr(ADDR_LDO, 16'h0001);
    chk("ldo", convOut[0].mode, MODE_LDO);
    reg_wr(ADDR_TEST[0], 16'h0010);
    chk("fixed pwm", convOut[0].fixedPwm, 1'b1);
    reg_wr(ADDR_VOLT[0], 16'h0026);
    chk("voltage", convOut[0].code, 7'h26);
    reg_wr(ADDR_LDO, 16'h0000);
    reg_wr(ADDR_LP[0], 16'h3106);
    reg_wr(ADDR_SLOTS[3], 16'h0080);
    lpIn.trig <= 3'b001;
    repeat (6) @(posedge clk);
    chk("lp mode", convOut[0].mode, MODE_STANDBY);
    chk("lp image", convOut[0].code, IMG_RESET);
    lpIn.trig <= 3'b000;
    lpIn.ena <= 1'b1;
    repeat (6) @(posedge clk);
    chk("global hib", convOut[2].code, IMG_RESET);
    lpIn.ena <= 1'b0;
    convInhibit <= 1'b1;
    repeat (3) @(posedge clk);
    chk("inhibit", convOut[0].on, 1'b0);
    convInhibit <= 1'b0;
    startupReq <= 1'b0;
    shutdownReq <= 1'b1;
    repeat (73) @(posedge clk);
    chk("slot2 shutdown", convOut[3].on, 1'b0);
    chk("late shutdown", convOut[0].on, 1'b1);
    wait_flag(0);
    chk("off", convOut[0].on, 1'b0);
    chk("off mode", convOut[0].mode, MODE_OFF);
    chk("discharge", convOut[0].discharge, 1'b1);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    reg_rd(ADDR_VOLT[0]);
    chk("volt reset", rd, {25'h0000000, VOLT_RESET});
    chk("reset off", offState, 1'b1);
    stop_test();
  end
endmodule : dcdc_converter_control_tb_top
`default_nettype wire
